// File: core/nsp_access.sv
/*
  Self-program access unit: address, data, control and unlock registers
  on an AXI4-Lite slave, read and unlock-protected row writes of flash.
  Assumes the core stalls while stall_o is high and skips one
  instruction after a write trigger.
*/
// How it works
// [RQ1] low data register: 8-bit read/write, reset content undefined
// [RQ2] high data register holds word bits 13:8; top two bits read zero
// [RQ3] low address register: address bits 7:0, read/write, reset zero
// [RQ4] high address register: bits 14:8 in 6:0, bit 7 reads one
// [RQ5] software loads address, clears config select, sets program select
// [RQ6] write begins only after 55h then AAh to unlock, then write trigger
// [RQ7] after trigger one instruction ignored, core stalls until write done
// [RQ8] latch-only bit set: trigger loads latch; clear: flash programs
// [RQ9] row is eight words; software triggers programming at low bits seven
// [RQ10] software disables interrupts around the unlock sequence
// [RQ11] trigger ignored unless write permit set and unlock just preceded
`timescale 1ns/1ps
module nsp_access #(
  parameter int AW = 6,
  parameter int PROG_CYCLES = nsp_pkg::NSP_PROG_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic stall_o,
  output logic skip_o
);
  import nsp_pkg::*;

  logic [7:0] dlo_q, dlo_d;
  logic [5:0] dhi_q, dhi_d;
  logic [7:0] alo_q, alo_d;
  logic [6:0] ahi_q, ahi_d;
  logic [7:0] ctl_q, ctl_d;
  logic [1:0] key_q, key_d;
  nsp_state_e st_q, st_d;
  logic [15:0] cnt_q, cnt_d;
  logic stall_q, stall_d, skip_q, skip_d;
  logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
  logic rdy_aw_q, rdy_aw_d, rdy_w_q, rdy_w_d, rdy_ar_q, rdy_ar_d;
  logic [7:0] awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [3:0] ws_q, ws_d;
  logic [1:0] br_q, br_d, rr_q, rr_d;
  logic [13:0] mem_word;
  logic st_latch, st_commit;
  logic do_wr, do_rd;
  logic [7:0] wb;
  logic wmap, rmap;
  logic [31:0] rword;

  // flash array with row latch, addressed by the low location bits
  nsp_store #(.AW(AW), .ROW(NSP_ROW_WORDS)) u_store (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .addr_i(alo_q[AW-1:0]),
    .wdata_i({dhi_q, dlo_q}),
    .latch_i(st_latch),
    .commit_i(st_commit),
    .rdata_o(mem_word)
  );

  // bus channel capture and register decode
  always_comb begin
    aw_d = aw_q;
    w_d = w_q;
    awa_d = awa_q;
    wd_d = wd_q;
    ws_d = ws_q;
    bv_d = bv_q;
    br_d = br_q;
    rv_d = rv_q;
    rr_d = rr_q;
    rd_d = rd_q;
    if (s_axi_awvalid_i && !aw_q && !bv_q) begin
      aw_d = 1'b1;
      awa_d = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && !w_q && !bv_q) begin
      w_d = 1'b1;
      wd_d = s_axi_wdata_i;
      ws_d = s_axi_wstrb_i;
    end
    do_wr = aw_q && w_q && !bv_q;
    wb = wd_q[7:0];
    wmap = awa_q <= NSP_UNLOCK_OFS && awa_q[1:0] == 2'b00;
    if (do_wr) begin
      aw_d = 1'b0;
      w_d = 1'b0;
      bv_d = 1'b1;
      br_d = wmap ? NSP_RESP_OKAY : NSP_RESP_SLVERR;
    end
    if (bv_q && s_axi_bready_i) bv_d = 1'b0;
    rmap = s_axi_araddr_i <= NSP_STATUS_OFS && s_axi_araddr_i[1:0] == 2'b00;
    case (s_axi_araddr_i)
      NSP_DATA_LOW_OFS: rword = {24'h00_0000, dlo_q}; // [RQ1]
      NSP_DATA_HIGH_OFS: rword = {26'h000_0000, dhi_q}; // [RQ2]
      NSP_ADDR_LOW_OFS: rword = {24'h00_0000, alo_q}; // [RQ3]
      NSP_ADDR_HIGH_OFS: begin
        rword = {24'h00_0000, NSP_ADDR_HIGH_ONE | {1'b0, ahi_q}}; // [RQ4]
      end
      NSP_CONTROL_OFS: rword = {24'h00_0000, ctl_q};
      NSP_STATUS_OFS: rword = {30'h0000_0000, skip_q, stall_q};
      default: rword = 32'h0000_0000;
    endcase
    do_rd = s_axi_arvalid_i && !rv_q;
    if (do_rd) begin
      rv_d = 1'b1;
      rd_d = rword;
      rr_d = rmap ? NSP_RESP_OKAY : NSP_RESP_SLVERR;
    end
    if (rv_q && s_axi_rready_i) rv_d = 1'b0;
    // readies registered from the next channel state
    rdy_aw_d = !aw_d && !bv_d;
    rdy_w_d = !w_d && !bv_d;
    rdy_ar_d = !rv_d;
  end

  // register file, unlock tracking and operation sequencer
  always_comb begin
    dlo_d = dlo_q;
    dhi_d = dhi_q;
    alo_d = alo_q;
    ahi_d = ahi_q;
    ctl_d = ctl_q;
    key_d = key_q;
    st_d = st_q;
    cnt_d = cnt_q;
    stall_d = stall_q;
    skip_d = 1'b0;
    st_latch = 1'b0;
    st_commit = 1'b0;
    if (do_wr && ws_q[0]) begin
      // any bus write with byte lane 0 strobed, other than the expected key, breaks the sequence
      key_d = 2'd0; // [RQ11]
      case (awa_q)
        NSP_DATA_LOW_OFS: dlo_d = wb; // [RQ1]
        NSP_DATA_HIGH_OFS: dhi_d = wb[5:0] & NSP_DATA_HIGH_MASK; // [RQ2]
        NSP_ADDR_LOW_OFS: alo_d = wb; // [RQ3]
        NSP_ADDR_HIGH_OFS: ahi_d = wb[6:0]; // [RQ4]
        NSP_UNLOCK_OFS: begin
          if (key_q == 2'd0 && wb == NSP_KEY_FIRST) key_d = 2'd1; // [RQ6]
          else if (key_q == 2'd1 && wb == NSP_KEY_SECOND) key_d = 2'd2; // [RQ6]
        end
        NSP_CONTROL_OFS: begin
          ctl_d[NSP_CTL_PERMIT_BIT] = wb[NSP_CTL_PERMIT_BIT];
          ctl_d[NSP_CTL_LATCH_BIT] = wb[NSP_CTL_LATCH_BIT];
          ctl_d[NSP_CTL_CFG_BIT] = wb[NSP_CTL_CFG_BIT];
          ctl_d[NSP_CTL_PROG_BIT] = wb[NSP_CTL_PROG_BIT];
          if (st_q == NSP_IDLE && wb[NSP_CTL_READ_BIT]) begin
            ctl_d[NSP_CTL_READ_BIT] = 1'b1; // [RQ5]
            st_d = NSP_READ;
            cnt_d = 16'(NSP_READ_CYCLES);
          end else if (st_q == NSP_IDLE && wb[NSP_CTL_WRITE_BIT] &&
                       wb[NSP_CTL_PERMIT_BIT] && key_q == 2'd2) begin
            ctl_d[NSP_CTL_WRITE_BIT] = 1'b1; // [RQ11]
            stall_d = 1'b1; // [RQ7]
            skip_d = 1'b1; // [RQ7]
            if (wb[NSP_CTL_LATCH_BIT]) begin
              st_d = NSP_LATCH; // [RQ8]
              cnt_d = 16'(NSP_LATCH_CYCLES);
            end else begin
              st_d = NSP_PROG; // [RQ8]
              cnt_d = 16'(PROG_CYCLES);
            end
          end
        end
        default: ;
      endcase
    end
    // sequencer counts down and finishes the operation
    case (st_q)
      NSP_IDLE: ;
      NSP_READ: begin
        cnt_d = cnt_q - 16'd1;
        if (cnt_q == 16'd1) begin
          dlo_d = mem_word[7:0]; // [RQ5]
          dhi_d = mem_word[13:8];
          ctl_d[NSP_CTL_READ_BIT] = 1'b0;
          st_d = NSP_IDLE;
        end
      end
      NSP_LATCH, NSP_PROG: begin
        cnt_d = cnt_q - 16'd1;
        if (cnt_q == 16'd1) begin
          st_latch = 1'b1; // [RQ8]
          st_commit = st_q == NSP_PROG; // [RQ8]
          ctl_d[NSP_CTL_WRITE_BIT] = 1'b0;
          stall_d = 1'b0; // [RQ7]
          st_d = NSP_IDLE;
        end
      end
      default: st_d = NSP_IDLE;
    endcase
  end

  // register all state
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      dlo_q <= 8'h00;
      dhi_q <= 6'h00;
      alo_q <= NSP_ADDR_RESET; // [RQ3]
      ahi_q <= 7'h00; // [RQ4]
      ctl_q <= NSP_CTL_RESET;
      key_q <= 2'd0;
      st_q <= NSP_IDLE;
      cnt_q <= 16'h0000;
      stall_q <= 1'b0;
      skip_q <= 1'b0;
      aw_q <= 1'b0;
      w_q <= 1'b0;
      bv_q <= 1'b0;
      rv_q <= 1'b0;
      rdy_aw_q <= 1'b1;
      rdy_w_q <= 1'b1;
      rdy_ar_q <= 1'b1;
      awa_q <= 8'h00;
      wd_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      rd_q <= 32'h0000_0000;
      br_q <= 2'b00;
      rr_q <= 2'b00;
    end else begin
      dlo_q <= dlo_d;
      dhi_q <= dhi_d;
      alo_q <= alo_d;
      ahi_q <= ahi_d;
      ctl_q <= ctl_d;
      key_q <= key_d;
      st_q <= st_d;
      cnt_q <= cnt_d;
      stall_q <= stall_d;
      skip_q <= skip_d;
      aw_q <= aw_d;
      w_q <= w_d;
      bv_q <= bv_d;
      rv_q <= rv_d;
      rdy_aw_q <= rdy_aw_d;
      rdy_w_q <= rdy_w_d;
      rdy_ar_q <= rdy_ar_d;
      awa_q <= awa_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      rd_q <= rd_d;
      br_q <= br_d;
      rr_q <= rr_d;
    end
  end

  // outputs straight from flip-flops
  assign s_axi_awready_o = rdy_aw_q;
  assign s_axi_wready_o = rdy_w_q;
  assign s_axi_bvalid_o = bv_q;
  assign s_axi_bresp_o = br_q;
  assign s_axi_arready_o = rdy_ar_q;
  assign s_axi_rvalid_o = rv_q;
  assign s_axi_rdata_o = rd_q;
  assign s_axi_rresp_o = rr_q;
  assign stall_o = stall_q;
  assign skip_o = skip_q;
endmodule

// File: core/nsp_pkg.sv
/*
  Package for the self-program access unit: register offsets, field
  positions, reset values, unlock keys and timing counts.
  Assumes a 250 MHz system clock and an AXI4-Lite register bus.
*/
package nsp_pkg;
  // register byte addresses
  localparam logic [7:0] NSP_DATA_LOW_OFS = 8'h00;
  localparam logic [7:0] NSP_DATA_HIGH_OFS = 8'h04;
  localparam logic [7:0] NSP_ADDR_LOW_OFS = 8'h08;
  localparam logic [7:0] NSP_ADDR_HIGH_OFS = 8'h0C;
  localparam logic [7:0] NSP_CONTROL_OFS = 8'h10;
  localparam logic [7:0] NSP_UNLOCK_OFS = 8'h14;
  localparam logic [7:0] NSP_STATUS_OFS = 8'h18;
  // control field positions
  localparam int NSP_CTL_READ_BIT = 0;
  localparam int NSP_CTL_WRITE_BIT = 1;
  localparam int NSP_CTL_PERMIT_BIT = 2;
  localparam int NSP_CTL_LATCH_BIT = 5;
  localparam int NSP_CTL_CFG_BIT = 6;
  localparam int NSP_CTL_PROG_BIT = 7;
  // reset values and fixed bits
  localparam logic [7:0] NSP_ADDR_RESET = 8'h00;
  localparam logic [7:0] NSP_CTL_RESET = 8'h00;
  localparam logic [7:0] NSP_ADDR_HIGH_ONE = 8'h80;
  localparam logic [5:0] NSP_DATA_HIGH_MASK = 6'h3F;
  // unlock keys
  localparam logic [7:0] NSP_KEY_FIRST = 8'h55;
  localparam logic [7:0] NSP_KEY_SECOND = 8'hAA;
  // geometry
  localparam int NSP_ROW_WORDS = 8;
  localparam logic [2:0] NSP_ROW_LAST = 3'h7;
  // timing: programming time in ns, cycle period in ns
  localparam int NSP_CLK_NS = 4;
  localparam int NSP_PROG_NS = 2000;
  localparam int NSP_PROG_CYCLES = (NSP_PROG_NS + NSP_CLK_NS - 1) / NSP_CLK_NS;
  localparam int NSP_LATCH_CYCLES = 1;
  localparam int NSP_READ_CYCLES = 2;
  // AXI responses
  localparam logic [1:0] NSP_RESP_OKAY = 2'b00;
  localparam logic [1:0] NSP_RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    NSP_IDLE, NSP_READ, NSP_LATCH, NSP_PROG
  } nsp_state_e;
endpackage

// File: core/nsp_store.sv
/*
  Flip-flop model of the program flash with a row write latch.
  Assumes one clock, asynchronous active-high reset, and requests that
  come only from the self-program access unit.
*/
`timescale 1ns/1ps
module nsp_store #(
  parameter int AW = 6,
  parameter int ROW = 8
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [13:0] wdata_i,
  input wire logic latch_i,
  input wire logic commit_i,
  output logic [13:0] rdata_o
);
  import nsp_pkg::*;
  localparam int RB = $clog2(ROW);
  logic [13:0] mem_q [2**AW];
  logic [13:0] mem_d [2**AW];
  logic [13:0] latch_q [ROW];
  logic [13:0] latch_d [ROW];
  logic [13:0] rdata_d;
  logic [13:0] rdata_q;

  // next-state of array, latches and read word
  always_comb begin
    mem_d = mem_q;
    latch_d = latch_q;
    rdata_d = mem_q[addr_i];
    if (latch_i) begin
      latch_d[addr_i[RB-1:0]] = wdata_i;
    end
    if (commit_i) begin
      for (int i = 0; i < ROW; i++) begin
        mem_d[{addr_i[AW-1:RB], RB'(i)}] = latch_d[i];
      end
    end
  end

  // register storage
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < 2**AW; i++) mem_q[i] <= 14'h3FFF;
      for (int i = 0; i < ROW; i++) latch_q[i] <= 14'h3FFF;
      rdata_q <= 14'h0000;
    end else begin
      mem_q <= mem_d;
      latch_q <= latch_d;
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o = rdata_q;
endmodule

// File: dv/nsp_access_chk.sv
/*
  Concurrent checks for the self-program access unit.
  Assumes it is bound onto nsp_access and sees only its ports.
*/
`timescale 1ns/1ps
module nsp_access_chk
  import nsp_pkg::*;
#(
  parameter int PROG_CYCLES = 500
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic stall_o,
  input wire logic skip_o
);
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // length of the current stall run
  always_comb cnt_d = stall_o ? cnt_q + 16'h0001 : 16'h0000;

  // register the stall run length
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) cnt_q <= 16'h0000;
    else cnt_q <= cnt_d;
  end

  chk_rd_upper_zero: assert property (
    s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h00_0000)
    else $error("read data above byte not zero");
  chk_data_high_top: assert property (
    $rose(s_axi_rvalid_o) && $past(s_axi_araddr_i) == NSP_DATA_HIGH_OFS
    |-> s_axi_rdata_o[7:6] == 2'b00)
    else $error("data high top bits not zero");
  chk_addr_high_top: assert property (
    $rose(s_axi_rvalid_o) && $past(s_axi_araddr_i) == NSP_ADDR_HIGH_OFS
    |-> s_axi_rdata_o[7])
    else $error("address high bit 7 not one");
  chk_skip_one_cycle: assert property (
    skip_o |=> !skip_o)
    else $error("skip longer than one cycle");
  chk_stall_bounded: assert property (
    cnt_q <= 16'(PROG_CYCLES))
    else $error("stall longer than programming time");
  chk_bvalid_hold: assert property (
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
    else $error("write response dropped early");
  chk_rvalid_hold: assert property (
    s_axi_rvalid_o && !s_axi_rready_i
    |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read response dropped or changed");
  chk_wr_blocked: assert property (
    s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write accepted while response pending");
endmodule

bind nsp_access nsp_access_chk #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
  .clk_i(clk_i), .reset_i(reset_i), .s_axi_awready_o(s_axi_awready_o),
  .s_axi_wready_o(s_axi_wready_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_araddr_i(s_axi_araddr_i),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
  .s_axi_rdata_o(s_axi_rdata_o), .stall_o(stall_o), .skip_o(skip_o));

// File: dv/tb_top.sv
/*
  Self-checking bench for the self-program access unit.
  Assumes a 250 MHz clock and the checker bound onto the unit.
*/
`timescale 1ns/1ps
module tb_top;
  import nsp_pkg::*;
  localparam int PROG = 8;
  logic clk_i = 0;
  logic reset_i = 1;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic awready, wready, bvalid, arready, rvalid, stall, skip;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int n_errors = 0, checks_done = 0, cyc = 0, n_stall = 0, n_skip = 0;

  nsp_access #(.AW(6), .PROG_CYCLES(PROG)) dut (
    .clk_i(clk_i), .reset_i(reset_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .stall_o(stall), .skip_o(skip));

  // clock generator
  initial forever #2 clk_i = ~clk_i;

  // verdict and end of run
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // stall and skip counters, timeout watchdog
  always @(posedge clk_i) begin
    cyc++;
    if (stall === 1'b1) n_stall++;
    if (skip === 1'b1) n_skip++;
    if (cyc == 5000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic cmp(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask

  // one bus write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    output logic [1:0] r);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic w(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    wr(a, d, r);
  endtask

  // one bus read
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    cmp(nm, e, d);
  endtask

  // unlock keys on consecutive bus writes, nothing may come between
  task automatic keys();
    w(NSP_UNLOCK_OFS, NSP_KEY_FIRST);
    w(NSP_UNLOCK_OFS, NSP_KEY_SECOND);
  endtask

  // read one flash word; data registers settle two cycles after trigger
  task automatic rdword(input logic [7:0] a, input logic [13:0] e);
    w(NSP_ADDR_LOW_OFS, a);
    w(NSP_CONTROL_OFS, 8'h81);
    repeat (3) @(posedge clk_i);
    rchk("word low", NSP_DATA_LOW_OFS, 32'(e[7:0]));
    rchk("word high", NSP_DATA_HIGH_OFS, 32'(e[13:8]));
  endtask

  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    rchk("addr low", NSP_ADDR_LOW_OFS, 32'h0000_0000);
    rchk("addr high", NSP_ADDR_HIGH_OFS, 32'h0000_0080);
    w(NSP_DATA_LOW_OFS, 8'hA5);
    rchk("data low", NSP_DATA_LOW_OFS, 32'h0000_00A5);
    w(NSP_DATA_HIGH_OFS, 8'hFF);
    rchk("data high", NSP_DATA_HIGH_OFS, 32'h0000_003F);
    w(NSP_ADDR_LOW_OFS, 8'h5A);
    rchk("addr low", NSP_ADDR_LOW_OFS, 32'h0000_005A);
    w(NSP_ADDR_HIGH_OFS, 8'h2A);
    rchk("addr high", NSP_ADDR_HIGH_OFS, 32'h0000_00AA);
    wr(8'h1C, 8'h00, r);
    cmp("bresp", 32'(NSP_RESP_SLVERR), 32'(r));
    rd(8'h20, d, r);
    cmp("rresp", 32'(NSP_RESP_SLVERR), 32'(r));
    $display("test regs done");
  endtask

  // triggers without permit or a clean unlock must start nothing
  task automatic t_lock();
    int s;
    int k;
    s = n_stall;
    k = n_skip;
    w(NSP_CONTROL_OFS, 8'h86);
    keys();
    w(NSP_CONTROL_OFS, 8'h82);
    w(NSP_UNLOCK_OFS, NSP_KEY_FIRST);
    w(NSP_DATA_LOW_OFS, 8'h00);
    w(NSP_UNLOCK_OFS, NSP_KEY_SECOND);
    w(NSP_CONTROL_OFS, 8'h86);
    w(NSP_UNLOCK_OFS, NSP_KEY_SECOND);
    w(NSP_UNLOCK_OFS, NSP_KEY_FIRST);
    w(NSP_CONTROL_OFS, 8'h86);
    cmp("stall cycles", 32'(s), 32'(n_stall));
    cmp("skips", 32'(k), 32'(n_skip));
    w(NSP_CONTROL_OFS, 8'h00);
    $display("test lock done");
  endtask

  // latch seven words, program the row with the eighth, read it back
  task automatic t_row();
    int s;
    int k;
    logic [13:0] e;
    s = n_stall;
    k = n_skip;
    w(NSP_ADDR_HIGH_OFS, 8'h00);
    for (int i = 0; i < 8; i++) begin
      if (i == 7) rdword(8'h08, 14'h3FFF);
      w(NSP_ADDR_LOW_OFS, 8'(8 + i));
      w(NSP_DATA_LOW_OFS, 8'(8'hC0 + i));
      w(NSP_DATA_HIGH_OFS, 8'(8'h30 + i));
      keys();
      w(NSP_CONTROL_OFS, (i < 7) ? 8'hA6 : 8'h86);
      while (stall !== 1'b0) @(posedge clk_i);
    end
    cmp("stall cycles", 32'(7 + PROG), 32'(n_stall - s));
    cmp("skips", 32'h0000_0008, 32'(n_skip - k));
    rchk("control", NSP_CONTROL_OFS, 32'h0000_0084);
    for (int i = 0; i < 8; i++) begin
      e = {6'h30 + 6'(i), 8'hC0 + 8'(i)};
      rdword(8'(8 + i), e);
    end
    $display("test row done");
  endtask

  // main sequence
  initial begin
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_lock();
    t_row();
    end_sim();
  end
endmodule
